// ### design/led_display_defines.vh
// register map, field positions, reset values and timing counts
`ifndef LED_DISPLAY_DEFINES_VH
`define LED_DISPLAY_DEFINES_VH

// register indices (printed offsets); byte address is index times four
`define IDX_BRIGHT_01 8'h01
`define IDX_BRIGHT_23 8'h02
`define IDX_SCAN_COUNT 8'h03
`define IDX_SHUTDOWN 8'h04
`define IDX_GLYPH_PORT 8'h05
`define IDX_DISPLAY_TEST 8'h07
`define IDX_GLYPH_PTR 8'h08

// field positions
`define FONT_CMD_BIT 7
`define SCAN_ALL_BIT 0
`define TEST_BIT 0
`define SHUTDOWN_RUN_BIT 0

// reset values
`define RST_BRIGHT 8'h00
`define RST_SCAN 8'h00
`define RST_SHUTDOWN 8'h00
`define RST_TEST 8'h00
`define RST_GLYPH_PTR 8'h80

// font pointer range
`define GLYPH_PTR_FIRST 8'h80
`define GLYPH_PTR_LAST 8'hF7

// pwm timing
`define PWM_STEPS 5'h10
`define TEST_DUTY 4'h7
`define TEST_PHASES 4'h8
`define SCAN_TICK_NS 1000
`define CLK_PERIOD_NS 25
`define SCAN_TICK_CYCLES (`SCAN_TICK_NS / `CLK_PERIOD_NS)

`endif

// ### design/pwm_slot.v
// one pwm slot counter with phase end pulse for the multiplex scanner
`timescale 1ns/1ps
`include "led_display_defines.vh"

module pwm_slot #(
  parameter TICK_CYCLES = `SCAN_TICK_CYCLES
) (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  output reg [3:0] slot, // current sixteenth within a phase
  output reg phase_end // pulse in the cycle after the last tick of a phase
);

  reg [15:0] tick_cnt;
  wire tick_done;

  assign tick_done = (tick_cnt == TICK_CYCLES - 1);

  // ==========================================================
  // slot stepping
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 16'h0000;
      slot <= 4'h0;
      phase_end <= 1'b0;
    end else begin
      phase_end <= tick_done && (slot == 4'hF);
      if (tick_done) begin
        tick_cnt <= 16'h0000;
        slot <= slot + 4'h1;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

endmodule

// ### design/led_matrix_display_control.v
// display control: test override, user glyph ram, scan limit, brightness
// Overview of operation
// - Two display modes exist, normal and test, picked by a test register.
// - Test lights every led and leaves all stored registers untouched.
// - Test lights the leds even while shutdown is stored as programmed.
// - Test scans eight digit phases at a fixed 7/16 duty.
// - A glyph port write with the top bit set loads the glyph pointer.
// - A glyph port write with the top bit clear stores seven bits and steps the pointer.
// - Scan bit zero clear scans only digits 0 and 1, other bits ignored.
// - Scan bit zero set scans all four digits.
// - Low nibbles set brightness of digit 0 and digit 2.
// - High nibbles set brightness of digits 1 and 3.
// - Digits 0 and 1 are driven together, then digits 2 and 3.
// - An access at the last pointer location wraps the pointer to the first.
`timescale 1ns/1ps
`include "led_display_defines.vh"

module led_matrix_display_control #(
  parameter TICK_CYCLES = `SCAN_TICK_CYCLES,
  parameter GLYPH_WORDS = 120
) (
  input wire pclk, // apb clock, 40 MHz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction, high for write
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready, always high
  output reg [31:0] prdata, // apb read data
  output wire pslverr, // apb error on unmapped address
  output reg [3:0] digit_enable, // one bit per digit being lit
  output reg all_on, // forces every segment on (test mode)
  output reg [7:0] glyph_rd_data // column at current glyph pointer
);

  // ==========================================================
  // register storage
  reg [7:0] brightness_digits_zero_one;
  reg [7:0] brightness_digits_two_three;
  reg [7:0] scan_digit_count;
  reg [7:0] shutdown_ctrl;
  reg [7:0] display_test;
  reg [7:0] glyph_ptr;
  reg [6:0] user_glyph_ram [0:GLYPH_WORDS-1];
  reg [2:0] phase;

  wire [3:0] slot;
  wire phase_end;
  wire [5:0] reg_idx;
  wire addr_ok;
  wire access;
  wire wr_en;
  wire rd_en;
  wire glyph_access;
  wire glyph_wr_data;
  wire glyph_wr_ptr;
  wire test_mode;
  wire scan_all;
  wire [6:0] ram_index;

  // ==========================================================
  // functions
  function [7:0] ptr_step;
    input [7:0] ptr;
    begin
      if (ptr >= `GLYPH_PTR_LAST)
        ptr_step = `GLYPH_PTR_FIRST;
      else
        ptr_step = ptr + 8'h01;
    end
  endfunction

  // nibble n lit for slots 0..n, capped so slot 15 is blank
  function duty_on;
    input [3:0] level;
    input [3:0] s;
    begin
      duty_on = (s <= level) && (s != 4'hF);
    end
  endfunction

  function reg_hit;
    input [5:0] idx;
    begin
      reg_hit = (idx == `IDX_BRIGHT_01) || (idx == `IDX_BRIGHT_23) ||
                (idx == `IDX_SCAN_COUNT) || (idx == `IDX_SHUTDOWN) ||
                (idx == `IDX_GLYPH_PORT) || (idx == `IDX_DISPLAY_TEST) ||
                (idx == `IDX_GLYPH_PTR);
    end
  endfunction

  // ==========================================================
  // apb decode
  assign reg_idx = paddr[7:2];
  assign addr_ok = reg_hit(reg_idx) && (paddr[1:0] == 2'b00);
  assign access = psel && penable;
  assign wr_en = access && pwrite && addr_ok;
  assign rd_en = access && !pwrite && addr_ok;
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;
  assign glyph_access = (reg_idx == `IDX_GLYPH_PORT) && (wr_en || rd_en);
  assign glyph_wr_ptr = wr_en && (reg_idx == `IDX_GLYPH_PORT) &&
                        pwdata[`FONT_CMD_BIT];
  assign glyph_wr_data = wr_en && (reg_idx == `IDX_GLYPH_PORT) &&
                         !pwdata[`FONT_CMD_BIT];
  assign ram_index = glyph_ptr[6:0];
  assign test_mode = display_test[`TEST_BIT];
  assign scan_all = scan_digit_count[`SCAN_ALL_BIT];

  // ==========================================================
  // control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brightness_digits_zero_one <= `RST_BRIGHT;
      brightness_digits_two_three <= `RST_BRIGHT;
      scan_digit_count <= `RST_SCAN;
      shutdown_ctrl <= `RST_SHUTDOWN;
      display_test <= `RST_TEST;
    end else if (wr_en) begin
      case (reg_idx)
        `IDX_BRIGHT_01: begin
          brightness_digits_zero_one <= pwdata[7:0];
        end
        `IDX_BRIGHT_23: begin
          brightness_digits_two_three <= pwdata[7:0];
        end
        `IDX_SCAN_COUNT: begin
          scan_digit_count <= pwdata[7:0];
        end
        `IDX_SHUTDOWN: begin
          shutdown_ctrl <= pwdata[7:0];
        end
        `IDX_DISPLAY_TEST: begin
          display_test <= pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // glyph pointer and ram
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glyph_ptr <= `RST_GLYPH_PTR;
    end else if (glyph_wr_ptr) begin
      if (pwdata[7:0] > `GLYPH_PTR_LAST)
        glyph_ptr <= `GLYPH_PTR_FIRST;
      else
        glyph_ptr <= pwdata[7:0];
    end else if (glyph_wr_data || (glyph_access && rd_en)) begin
      glyph_ptr <= ptr_step(glyph_ptr);
    end else if (wr_en && (reg_idx == `IDX_GLYPH_PTR)) begin
      // same clamp as the port load: above 0xF7 loads 0x80, lower values are stored as written
      if (pwdata[7:0] > `GLYPH_PTR_LAST)
        glyph_ptr <= `GLYPH_PTR_FIRST;
      else
        glyph_ptr <= pwdata[7:0];
    end
  end

  always @(posedge pclk) begin
    if (glyph_wr_data)
      user_glyph_ram[ram_index] <= pwdata[6:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      glyph_rd_data <= 8'h00;
    else
      glyph_rd_data <= {1'b0, user_glyph_ram[ram_index]};
  end

  // ==========================================================
  // read mux
  always @* begin
    prdata = 32'h00000000;
    case (reg_idx)
      `IDX_BRIGHT_01: prdata[7:0] = brightness_digits_zero_one;
      `IDX_BRIGHT_23: prdata[7:0] = brightness_digits_two_three;
      `IDX_SCAN_COUNT: prdata[7:0] = scan_digit_count;
      `IDX_SHUTDOWN: prdata[7:0] = shutdown_ctrl;
      `IDX_GLYPH_PORT: prdata[7:0] = {1'b0, user_glyph_ram[ram_index]};
      `IDX_DISPLAY_TEST: prdata[7:0] = display_test;
      `IDX_GLYPH_PTR: prdata[7:0] = glyph_ptr;
      default: prdata = 32'h00000000;
    endcase
  end

  // ==========================================================
  // multiplex scanner
  pwm_slot #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_slot (
    .pclk(pclk),
    .presetn(presetn),
    .slot(slot),
    .phase_end(phase_end)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 3'h0;
    end else if (phase_end) begin
      if (test_mode)
        phase <= phase + 3'h1;
      else if (scan_all)
        phase <= {2'b00, ~phase[0]};
      else
        phase <= 3'h0;
    end
  end

  // ==========================================================
  // digit drive
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digit_enable <= 4'h0;
      all_on <= 1'b0;
    end else if (test_mode) begin
      // stored control untouched; shutdown ignored in test
      all_on <= 1'b1;
      if (slot < `TEST_DUTY)
        digit_enable <= phase[0] ? 4'hC : 4'h3;
      else
        digit_enable <= 4'h0;
    end else if (!shutdown_ctrl[`SHUTDOWN_RUN_BIT]) begin
      all_on <= 1'b0;
      digit_enable <= 4'h0;
    end else begin
      all_on <= 1'b0;
      // a stale odd phase must not light the upper pair in two-digit scan
      if (!(scan_all && phase[0]))
        digit_enable <= {2'b00,
          duty_on(brightness_digits_zero_one[7:4], slot),
          duty_on(brightness_digits_zero_one[3:0], slot)};
      else
        digit_enable <= {
          duty_on(brightness_digits_two_three[7:4], slot),
          duty_on(brightness_digits_two_three[3:0], slot), 2'b00};
    end
  end

endmodule

// ### verif/led_display_monitor.sv
// port checker for the led display control block
`timescale 1ns/1ps
module led_display_monitor #(
  parameter TICK_CYCLES = 2
) (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // select
  input wire penable, // access
  input wire pwrite, // write
  input wire [7:0] paddr, // address
  input wire [31:0] pwdata, // write data
  input wire pready, // ready
  input wire [31:0] prdata, // read data
  input wire pslverr, // error
  input wire [3:0] digit_enable, // lit digits
  input wire all_on, // test mode
  input wire [7:0] glyph_rd_data // glyph column
);
  logic scan_all;
  logic was_on;
  logic [9:0] run;
  wire wr = psel && penable && pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // run counts consecutive lit cycles of digit 0 within one mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_all <= 1'b0;
      was_on <= 1'b0;
      run <= 10'h000;
    end else begin
      if (wr && paddr == 8'h0C)
        scan_all <= pwdata[0];
      was_on <= all_on;
      run <= (digit_enable[0] && all_on == was_on) ? run + 10'h001 : 10'h000;
    end
  end
  test_enter_a:
    assert property (wr && paddr == 8'h1C && pwdata[0] |-> ##2 all_on)
    else $error("test mode not entered");
  test_exit_a:
    assert property (wr && paddr == 8'h1C && !pwdata[0] |-> ##2 !all_on)
    else $error("test mode not left");
  digit_pair_a:
    assert property (!(|digit_enable[1:0] && |digit_enable[3:2]))
    else $error("both digit pairs lit");
  scan_two_a:
    assert property (!all_on && !was_on && !scan_all && !$past(scan_all)
      |-> digit_enable[3:2] == 2'b00)
    else $error("upper digits lit with two-digit scan");
  glyph_msb_a:
    assert property (psel && penable && !pwrite && paddr == 8'h14
      |-> prdata[7] == 1'b0)
    else $error("glyph read top bit set");
  duty_max_a:
    assert property (run <= 15 * TICK_CYCLES)
    else $error("digit lit beyond fifteen slots");
  test_duty_a:
    assert property (all_on && was_on |-> run <= 7 * TICK_CYCLES)
    else $error("test duty above seven slots");
  unmapped_err_a:
    assert property (psel && penable && paddr == 8'h18 |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind led_matrix_display_control led_display_monitor #(
  .TICK_CYCLES(TICK_CYCLES)
) i_led_display_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .digit_enable, .all_on,
  .glyph_rd_data);

// ### verif/apb_host.sv
// apb master model standing in for the host processor
`timescale 1ns/1ps
module apb_host (
  input wire pclk, // clock
  input wire pready, // ready
  input wire [31:0] prdata, // read data
  input wire pslverr, // error
  output logic psel, // select
  output logic penable, // access
  output logic pwrite, // write
  output logic [7:0] paddr, // address
  output logic [31:0] pwdata // write data
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // released bus shows the inverse so stale values never look valid
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ### verif/tb.sv
// register and display scenarios for the led display control block
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, ev;
  logic [31:0] rv;
  wire psel, penable, pwrite, pready, pslverr, all_on;
  wire [7:0] paddr, glyph_rd_data;
  wire [31:0] pwdata, prdata;
  wire [3:0] digit_enable;
  int fails = 0, samples_checked = 0, c0, c1, c2, c3;
  logic [31:0] col [5] = '{32'h42, 32'h61, 32'h51, 32'h49, 32'h46};
  led_matrix_display_control #(.TICK_CYCLES(2)) i_led_matrix_display_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .digit_enable, .all_on, .glyph_rd_data);
  apb_host host (.pclk, .pready, .prdata, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rv, ev);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rv, ev);
    cmp("read", exp, rv);
  endtask
  // lit cycles per digit over n cycles, after the outputs settle
  task lit(input int n);
    repeat (4) @(posedge pclk);
    c0 = 0;
    c1 = 0;
    c2 = 0;
    c3 = 0;
    repeat (n) begin
      @(posedge pclk);
      c0 += digit_enable[0];
      c1 += digit_enable[1];
      c2 += digit_enable[2];
      c3 += digit_enable[3];
    end
  endtask
  function automatic int dty(input int k);
    return (k == 15 ? 15 : k + 1) * 2;
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    give_verdict();
  end
  initial begin
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i <= 4; i++) rd(8'(i * 4), 32'h0);
    rd(8'h1C, 32'h0);
    wr(8'h14, 32'h8A);
    rd(8'h20, 32'h8A);
    for (int i = 0; i < 5; i++) wr(8'h14, col[i]);
    rd(8'h20, 32'h8F);
    wr(8'h14, 32'h8A);
    @(posedge pclk);
    @(negedge pclk);
    cmp("glyph column", 32'h42, 32'(glyph_rd_data));
    for (int i = 0; i < 5; i++) rd(8'h14, col[i]);
    wr(8'h14, 32'hF7);
    wr(8'h14, 32'h11);
    rd(8'h20, 32'h80);
    wr(8'h14, 32'hF7);
    rd(8'h14, 32'h11);
    rd(8'h20, 32'h80);
    host.xfer(1'b0, 8'h18, 32'h0, rv, ev);
    cmp("error", 32'h1, 32'(ev));
    cmp("unmapped", 32'h0, rv);
    wr(8'h04, 32'h5A);
    wr(8'h0C, 32'hFE);
    wr(8'h1C, 32'h01);
    @(posedge pclk);
    @(negedge pclk);
    cmp("all_on", 32'h1, 32'(all_on));
    lit(64);
    cmp("test digit0", 32'd14, 32'(c0));
    cmp("test digit2", 32'd14, 32'(c2));
    rd(8'h04, 32'h5A);
    rd(8'h10, 32'h0);
    wr(8'h1C, 32'hFE);
    @(posedge pclk);
    @(negedge pclk);
    cmp("all_on", 32'h0, 32'(all_on));
    wr(8'h10, 32'h01);
    lit(64);
    cmp("two digits", 32'h0, 32'(c2));
    wr(8'h10, 32'h00);
    wr(8'h0C, 32'h01);
    wr(8'h10, 32'h01);
    for (int n = 0; n < 16; n++) begin
      wr(8'h04, {24'h0, 4'(15 - n), 4'(n)});
      wr(8'h08, {24'h0, 4'(15 - n), 4'(n)});
      lit(64);
      cmp("digit0 duty", 32'(dty(n)), 32'(c0));
      cmp("digit1 duty", 32'(dty(15 - n)), 32'(c1));
      cmp("digit2 duty", 32'(dty(n)), 32'(c2));
      cmp("digit3 duty", 32'(dty(15 - n)), 32'(c3));
    end
    give_verdict();
  end
endmodule
